// File: hw/wdg_top.sv
// Watchdog timer with two safety levels, AHB-Lite register slave.
// Assumes restart, vector ack and device reset are one-cycle pulses on clock_i.
`timescale 1ns/1ps
module wdg_top #(
    parameter int BASE_PERIOD = wdg_pkg::BASE_PERIOD,
    parameter int CNT_W = wdg_pkg::CNT_W
) (
    // Clock and power-on reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // System side
    input wire logic dev_reset_i,
    input wire logic restart_i,
    input wire logic vector_ack_i,
    input wire logic safety_level_fuse_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [wdg_pkg::ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [wdg_pkg::DATA_W-1:0] hwdata_i,
    input wire logic hready_i,
    output logic [wdg_pkg::DATA_W-1:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Outputs to system
    output logic timeout_irq_o,
    output logic irq_o,
    output logic sys_reset_o,
    output logic dog_reset_cause_flag_o
);
    import wdg_pkg::*;

    // Fuse capture
    logic fuse_meta_q;
    logic fuse_sync_q;
    logic [1:0] cap_cnt_q;
    logic fuse_done_q;
    logic level2_q;

    // Control state
    logic flag_q;
    logic ie_q;
    logic wde_q;
    logic [3:0] sel_q;
    logic rflag_q;
    logic [2:0] win_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    wdg_pulse_e pst_q;
    logic [$clog2(RST_PULSE_CYCLES+1)-1:0] pcnt_q;

    // Bus data phase
    logic dp_wr_q;
    logic dp_ok_q;
    logic [5:0] dp_idx_q;

    logic tick;
    logic expire;
    logic ap_take;
    logic ap_ok;
    logic [7:0] wd;
    logic wr_ctrl;
    logic wr_rstc;
    logic wr_ccp;
    logic wr_stat;
    logic wr_mask;
    logic protect;
    logic wde_eff;
    logic stopped;
    logic run;
    logic do_reset;
    logic set_flag;
    logic combined;
    logic [7:0] ctrl_rd;
    logic [7:0] rd_val;

    // Oscillator rate as an enable keeps all state in one domain
    wdg_tick u_tick (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_o(tick)
    );

    wdg_count #(
        .CNT_W(CNT_W),
        .BASE(BASE_PERIOD)
    ) u_count (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .clear_i(restart_i || dev_reset_i),
        .run_i(run),
        .sel_i(sel_q),
        .expire_o(expire)
    );

    // Fuse pin: two-stage synchroniser, then caught once after release
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fuse_meta_q <= 1'b1;
            fuse_sync_q <= 1'b1;
        end else begin
            fuse_meta_q <= safety_level_fuse_i;
            fuse_sync_q <= fuse_meta_q;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_cnt_q <= 2'h0;
            fuse_done_q <= 1'b0;
            level2_q <= 1'b0;
        end else if (!fuse_done_q) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            if (cap_cnt_q == 2'h2) begin
                fuse_done_q <= 1'b1;
                level2_q <= !fuse_sync_q;
            end
        end
    end

    // Decode
    assign ap_take = hsel_i && hready_i && htrans_i[1];
    assign ap_ok = (haddr_i[ADDR_W-1:8] == '0) && (haddr_i[1:0] == 2'h0);
    assign wd = hwdata_i[7:0];
    assign wr_ctrl = dp_wr_q && dp_ok_q && (dp_idx_q == IDX_CTRL);
    assign wr_rstc = dp_wr_q && dp_ok_q && (dp_idx_q == IDX_RSTC);
    assign wr_ccp = dp_wr_q && dp_ok_q && (dp_idx_q == IDX_CCP);
    assign wr_stat = dp_wr_q && dp_ok_q && (dp_idx_q == IDX_ISTAT);
    assign wr_mask = dp_wr_q && dp_ok_q && (dp_idx_q == IDX_IMASK);
    assign protect = (win_q != 3'h0);

    // Mode selection
    assign wde_eff = wde_q || level2_q || rflag_q;
    assign stopped = !level2_q && !wde_eff && !ie_q;
    assign run = fuse_done_q && !stopped && !dev_reset_i;
    assign combined = !level2_q && wde_eff && ie_q;
    // With reset enabled, an unserviced flag at the next expiry escalates to reset
    assign do_reset = expire && (level2_q || (wde_eff && (!ie_q || flag_q)));
    assign set_flag = expire && !level2_q && ie_q && !do_reset;

    // Signature window, counted in clock cycles
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            win_q <= 3'h0;
        end else if (wr_ccp && wd == CCP_SIG) begin
            win_q <= CCP_WINDOW;
        end else if (wr_ctrl || dev_reset_i) begin
            win_q <= 3'h0;
        end else if (protect) begin
            win_q <= win_q - 3'h1;
        end
    end

    // Period select
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_q <= SEL_RESET;
        end else if (dev_reset_i) begin
            sel_q <= SEL_RESET;
        end else if (wr_ctrl && (!level2_q || protect)) begin
            // Reserved codes are refused and the old period stays
            if ({wd[CTRL_SEL3], wd[2:0]} <= SEL_MAX) begin
                sel_q <= {wd[CTRL_SEL3], wd[2:0]};
            end
        end
    end

    // Reset enable
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wde_q <= 1'b0;
        end else if (rflag_q) begin
            wde_q <= 1'b1;
        end else if (dev_reset_i || (!fuse_done_q && cap_cnt_q == 2'h2)) begin
            wde_q <= fuse_done_q ? level2_q : !fuse_sync_q;
        end else if (wr_ctrl && !level2_q) begin
            if (wd[CTRL_WDE]) begin
                wde_q <= 1'b1;
            end else if (protect) begin
                wde_q <= 1'b0;
            end
        end
    end

    // Interrupt enable
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ie_q <= 1'b0;
        end else if (dev_reset_i) begin
            ie_q <= 1'b0;
        end else if (wr_ctrl) begin
            ie_q <= wd[CTRL_IE];
        end else if (vector_ack_i && combined) begin
            ie_q <= 1'b0;
        end
    end

    // Time-out flag; a new event wins over either clear
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
        end else if (set_flag) begin
            flag_q <= 1'b1;
        end else if (dev_reset_i || vector_ack_i) begin
            flag_q <= 1'b0;
        end else if (wr_ctrl && wd[CTRL_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    // Reset-cause flag survives device reset, cleared by power-on or by writing zero to its bit in the reset-cause register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rflag_q <= 1'b0;
        end else if (do_reset) begin
            rflag_q <= 1'b1;
        end else if (wr_rstc && !wd[RSTC_FLAG]) begin
            rflag_q <= 1'b0;
        end
    end

    // Reset pulse generator
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pst_q <= WDG_IDLE;
            pcnt_q <= '0;
            sys_reset_o <= 1'b0;
        end else begin
            case (pst_q)
                WDG_IDLE: begin
                    if (do_reset) begin
                        pst_q <= WDG_PULSE;
                        pcnt_q <= '0;
                        sys_reset_o <= 1'b1;
                    end
                end
                WDG_PULSE: begin
                    if (pcnt_q == ($bits(pcnt_q))'(RST_PULSE_CYCLES - 1)) begin
                        pst_q <= WDG_IDLE;
                        sys_reset_o <= 1'b0;
                    end else begin
                        pcnt_q <= pcnt_q + 1'b1;
                    end
                end
                default: begin
                    pst_q <= WDG_IDLE;
                    sys_reset_o <= 1'b0;
                end
            endcase
        end
    end

    // Sticky event status, write one to clear; set wins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= EV_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == EV_TIMEOUT && set_flag) || (i == EV_DOGRST && do_reset)) begin
                    stat_q[i] <= 1'b1;
                end else if (dev_reset_i || (wr_stat && wd[i])) begin
                    stat_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_q <= EV_RESET;
        end else if (dev_reset_i) begin
            mask_q <= EV_RESET;
        end else if (wr_mask) begin
            mask_q <= wd[1:0];
        end
    end

    // Interrupt and reset-cause outputs
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timeout_irq_o <= 1'b0;
            irq_o <= 1'b0;
            dog_reset_cause_flag_o <= 1'b0;
        end else begin
            timeout_irq_o <= flag_q && ie_q;
            irq_o <= |(stat_q & mask_q);
            dog_reset_cause_flag_o <= rflag_q;
        end
    end

    // Read view; bit 4 is always zero
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[CTRL_FLAG] = flag_q;
        ctrl_rd[CTRL_IE] = ie_q;
        ctrl_rd[CTRL_SEL3] = sel_q[3];
        ctrl_rd[CTRL_WDE] = wde_eff;
        ctrl_rd[2:0] = sel_q[2:0];
        rd_val = 8'h00;
        if (ap_ok) begin
            case (haddr_i[7:2])
                IDX_CTRL: rd_val = ctrl_rd;
                IDX_RSTC: rd_val = {4'h0, rflag_q, 3'h0};
                IDX_ISTAT: rd_val = {6'h00, stat_q};
                IDX_IMASK: rd_val = {6'h00, mask_q};
                default: rd_val = 8'h00;
            endcase
        end
    end

    // Zero-wait slave: read data is fetched in the address phase
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dp_wr_q <= 1'b0;
            dp_ok_q <= 1'b0;
            dp_idx_q <= 6'h00;
            hrdata_o <= '0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            dp_wr_q <= ap_take && hwrite_i;
            dp_ok_q <= ap_ok && (hsize_i == 3'h2);
            dp_idx_q <= haddr_i[7:2];
            if (ap_take && !hwrite_i) begin
                hrdata_o <= {{(DATA_W-8){1'b0}}, rd_val};
            end
        end
    end
endmodule

// File: pkg/wdg_pkg.sv
// Constants, register layout and types of the watchdog block.
// Assumes a single 125 MHz system clock and word-aligned AHB-Lite access.
package wdg_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;

    // Clock and oscillator rates in kHz, clock period in ns
    localparam int CLK_KHZ = 125000;
    localparam int OSC_KHZ = 128;
    localparam int CLK_PERIOD_NS = 8;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h31;
    localparam logic [5:0] IDX_RSTC = 6'h3b;
    localparam logic [5:0] IDX_CCP = 6'h3c;
    localparam logic [5:0] IDX_ISTAT = 6'h20;
    localparam logic [5:0] IDX_IMASK = 6'h21;

    // Control/status field positions
    localparam int CTRL_FLAG = 7;
    localparam int CTRL_IE = 6;
    localparam int CTRL_SEL3 = 5;
    localparam int CTRL_WDE = 3;
    localparam int RSTC_FLAG = 3;

    // Reset values
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [1:0] EV_RESET = 2'h0;

    // Period selection
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam int BASE_PERIOD = 2048;
    localparam int CNT_W = 20;

    // Protected change
    localparam logic [7:0] CCP_SIG = 8'hd8;
    localparam logic [2:0] CCP_WINDOW = 3'h4;

    // Watchdog reset pulse width
    localparam int RST_PULSE_NS = 32;
    localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Interrupt status bits
    localparam int EV_TIMEOUT = 0;
    localparam int EV_DOGRST = 1;

    typedef enum logic [1:0] {
        WDG_IDLE = 2'b01,
        WDG_PULSE = 2'b10
    } wdg_pulse_e;

endpackage

// File: hw/wdg_tick.sv
// Oscillator-rate enable generator.
// Assumes the system clock is faster than the oscillator rate.
`timescale 1ns/1ps
module wdg_tick #(
    parameter int CLK_KHZ = wdg_pkg::CLK_KHZ,
    parameter int OSC_KHZ = wdg_pkg::OSC_KHZ
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Enable out
    output logic tick_o
);
    import wdg_pkg::*;

    localparam int ACC_W = $clog2(CLK_KHZ + OSC_KHZ + 1);
    localparam logic [ACC_W-1:0] STEP = ACC_W'(OSC_KHZ);
    localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_KHZ);

    if (OSC_KHZ < 1 || OSC_KHZ >= CLK_KHZ) begin : g_bad_rate
        $error("wdg_tick: oscillator rate must be below clock rate");
    end

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] sum;

    assign sum = acc_q + STEP;

    // Fractional divider keeps the average rate exact
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= '0;
            tick_o <= 1'b0;
        end else if (sum >= WRAP) begin
            acc_q <= sum - WRAP;
            tick_o <= 1'b1;
        end else begin
            acc_q <= sum;
            tick_o <= 1'b0;
        end
    end
endmodule

// File: hw/wdg_count.sv
// Watchdog period counter, advanced by the oscillator enable.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ps
module wdg_count #(
    parameter int CNT_W = wdg_pkg::CNT_W,
    parameter int BASE = wdg_pkg::BASE_PERIOD
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Control
    input wire logic tick_i,
    input wire logic clear_i,
    input wire logic run_i,
    input wire logic [3:0] sel_i,
    // Expiry
    output logic expire_o
);
    import wdg_pkg::*;

    if (BASE < 2 || (longint'(BASE) << SEL_MAX) > (longint'(1) << CNT_W)) begin : g_bad_base
        $error("wdg_count: base period does not fit the counter");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;

    assign limit = CNT_W'((longint'(BASE) << sel_i) - 1);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (clear_i || !run_i) begin
                cnt_q <= '0;
            end else if (tick_i) begin
                // Compare with >= so a shorter period takes effect at once
                if (cnt_q >= limit) begin
                    cnt_q <= '0;
                    expire_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule

// File: sim/wdg_top_assertions.sv
// Concurrent checks on the watchdog block's ports.
// Assumes one clock domain and a zero-wait register bus.
`timescale 1ns/1ps
module wdg_top_chk #(
    parameter int BASE_PERIOD = 2048,
    parameter int CNT_W = 20
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // System side
    input wire logic dev_reset_i,
    input wire logic restart_i,
    input wire logic vector_ack_i,
    input wire logic safety_level_fuse_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [wdg_pkg::ADDR_W-1:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [wdg_pkg::DATA_W-1:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Outputs
    input wire logic timeout_irq_o,
    input wire logic sys_reset_o,
    input wire logic dog_reset_cause_flag_o
);
    import wdg_pkg::*;
    logic [31:0] since_q;
    logic [3:0] up_q;
    wire logic rd_ctrl;
    assign rd_ctrl = hsel_i && hready_i && htrans_i[1] && !hwrite_i
        && haddr_i == {24'h0, IDX_CTRL, 2'b00};
    // Cycles since the last restart or device reset; a lower bound on any expiry
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_q <= '0;
            up_q <= '0;
        end else begin
            since_q <= (restart_i || dev_reset_i) ? '0 : since_q + {31'h0, since_q != '1};
            up_q <= up_q + {3'h0, up_q != 4'hf};
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    a_pulse_width: assert property ($rose(sys_reset_o) |-> sys_reset_o [*4] ##1 !sys_reset_o)
        else $error("reset pulse width wrong");
    a_cause_set: assert property ($rose(sys_reset_o) |-> ##[0:3] dog_reset_cause_flag_o)
        else $error("reset cause flag not set");
    a_min_period: assert property (($rose(sys_reset_o) || $rose(timeout_irq_o))
        |-> since_q >= 32'((BASE_PERIOD - 1) * 900)) else $error("expiry too early");
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or error");
    a_bit4_zero: assert property (rd_ctrl |=> hrdata_o[4] == 1'b0 && hrdata_o[31:8] == '0)
        else $error("reserved bits read nonzero");
    a_level2_wde: assert property (rd_ctrl && !safety_level_fuse_i && up_q == 4'hf
        |=> hrdata_o[3]) else $error("reset enable low at level two");
    a_flag_forces: assert property ((rd_ctrl && dog_reset_cause_flag_o) ##1
        dog_reset_cause_flag_o |-> hrdata_o[3]) else $error("reset enable not forced");
    a_vector_clear: assert property (vector_ack_i && timeout_irq_o |-> ##[1:3] !timeout_irq_o)
        else $error("vector did not clear request");
endmodule

bind wdg_top wdg_top_chk #(.BASE_PERIOD(BASE_PERIOD), .CNT_W(CNT_W)) chk_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .dev_reset_i(dev_reset_i), .restart_i(restart_i),
    .vector_ack_i(vector_ack_i), .safety_level_fuse_i(safety_level_fuse_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .timeout_irq_o(timeout_irq_o), .sys_reset_o(sys_reset_o),
    .dog_reset_cause_flag_o(dog_reset_cause_flag_o));

// File: sim/wdg_top_tb_top.sv
// Self-checking bench for the watchdog block.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module wdg_top_tb_top;
    import wdg_pkg::*;
    localparam logic [31:0] A_CTRL = {24'h0, IDX_CTRL, 2'b00};
    localparam logic [31:0] A_RSTC = {24'h0, IDX_RSTC, 2'b00};
    localparam logic [31:0] A_CCP = {24'h0, IDX_CCP, 2'b00};
    localparam logic [31:0] A_ISTAT = {24'h0, IDX_ISTAT, 2'b00};
    localparam logic [31:0] A_IMASK = {24'h0, IDX_IMASK, 2'b00};
    logic clock_i = 0;
    logic rst_n_i = 0;
    logic dev_reset_i = 0;
    logic restart_i = 0;
    logic vector_ack_i = 0;
    logic fuse = 1;
    logic hsel = 0;
    logic hwrite = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [31:0] rdat;
    logic [7:0] v;
    wire [31:0] hrdata;
    wire hready, hresp, irq_tmo, irq, sys_rst, cause;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 6;
    int rst_cycles = 0;
    int n;

    // Short base period keeps each code-zero expiry near four thousand clocks
    wdg_top #(.BASE_PERIOD(4), .CNT_W(20)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .dev_reset_i(dev_reset_i),
        .restart_i(restart_i), .vector_ack_i(vector_ack_i), .safety_level_fuse_i(fuse),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .timeout_irq_o(irq_tmo), .irq_o(irq),
        .sys_reset_o(sys_rst), .dog_reset_cause_flag_o(cause));

    always #4 clock_i = ~clock_i;

    // Watchdog reset is fed back as a device reset
    always @(posedge clock_i) begin
        dev_reset_i <= sys_rst;
        rst_cycles <= rst_cycles + (sys_rst ? 1 : 0);
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            num_errors++;
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        @(posedge clock_i);
        while (hready !== 1'b1) @(posedge clock_i);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge clock_i);
        while (hready !== 1'b1) @(posedge clock_i);
        rdat = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        check(nm, rdat, {24'h0, e});
    endtask

    // Signature then control write, inside the protection window
    task automatic pw(input logic [7:0] d);
        wr(A_CCP, CCP_SIG);
        wr(A_CTRL, d);
    endtask

    task automatic wait_for(input bit on_rst, input int lim);
        int k;
        k = 0;
        while (((on_rst ? sys_rst : irq_tmo) !== 1'b1) && k < lim) begin
            @(posedge clock_i);
            k++;
        end
        check("event", {31'h0, k < lim}, 32'h1);
        repeat (8) @(posedge clock_i);
    endtask

    task automatic pulse(input bit ack);
        if (ack)
            vector_ack_i <= 1'b1;
        else
            restart_i <= 1'b1;
        @(posedge clock_i);
        vector_ack_i <= 1'b0;
        restart_i <= 1'b0;
        @(posedge clock_i);
    endtask

    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        rd(A_CTRL, 8'h00, "ctrl init");
        rd(A_RSTC, 8'h00, "cause init");
        rd(32'h100, 8'h00, "unmapped");
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            v[7] = 1'b0;
            v[3] = 1'b0;
            if (v[5])
                v[2:1] = 2'b00;
            wr(A_CTRL, v);
            rd(A_CTRL, v & 8'hef, "ctrl rw");
        end
        wr(A_CTRL, 8'h22);
        rd(A_CTRL, v & 8'h27, "reserved code");
        wr(A_IMASK, 8'h01);
        wr(A_CTRL, 8'h40);
        wait_for(1'b0, 5000);
        rd(A_CTRL, 8'hc0, "flag set");
        check("irq", {31'h0, irq}, 32'h1);
        wr(A_CTRL, 8'hc0);
        rd(A_CTRL, 8'h40, "flag w1c");
        check("tmo irq", {31'h0, irq_tmo}, 32'h0);
        wr(A_ISTAT, 8'h01);
        wr(A_IMASK, 8'h00);
        repeat (2) @(posedge clock_i);
        check("irq clear", {31'h0, irq}, 32'h0);
        wait_for(1'b0, 5000);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd(A_ISTAT, 8'h01, "istat");
        pulse(1'b1);
        rd(A_CTRL, 8'h40, "vector");
        wr(A_ISTAT, 8'h01);
        wr(A_CTRL, 8'h48);
        wait_for(1'b0, 5000);
        rd(A_CTRL, 8'hc8, "first expiry");
        pulse(1'b1);
        rd(A_CTRL, 8'h08, "vector combined");
        wait_for(1'b1, 5000);
        rd(A_RSTC, 8'h08, "cause set");
        pw(8'h00);
        rd(A_CTRL, 8'h08, "forced wde");
        wr(A_RSTC, 8'h00);
        rd(A_RSTC, 8'h00, "cause clear");
        wr(A_CTRL, 8'h08);
        wr(A_CTRL, 8'h00);
        rd(A_CTRL, 8'h08, "plain disable");
        wr(A_CCP, CCP_SIG);
        repeat (6) @(posedge clock_i);
        wr(A_CTRL, 8'h00);
        rd(A_CTRL, 8'h08, "late disable");
        pw(8'h00);
        rd(A_CTRL, 8'h00, "protected disable");
        // Code one from a stopped counter: eight ticks plus output latency
        wr(A_CTRL, 8'h41);
        n = cyc;
        wait_for(1'b0, 9000);
        check("period one", {31'h0, cyc - n > 6830 && cyc - n < 7840}, 32'h1);
        // Clear the flag left by that expiry so later modes start clean
        wr(A_CTRL, 8'h88);
        n = rst_cycles;
        // Gaps stay well below the shortest period
        for (int i = 0; i < 6; i++) begin
            repeat ($unsigned($random(seed)) % 2000 + 500) @(posedge clock_i);
            pulse(1'b0);
        end
        check("restart", 32'(rst_cycles), 32'(n));
        pw(8'h00);
        wr(A_CTRL, 8'h48);
        wait_for(1'b0, 5000);
        wait_for(1'b1, 5000);
        check("cause", {31'h0, cause}, 32'h1);
        rst_n_i <= 1'b0;
        fuse <= 1'b0;
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        rd(A_CTRL, 8'h08, "level two");
        wr(A_CTRL, 8'h01);
        rd(A_CTRL, 8'h08, "plain period");
        pw(8'h01);
        rd(A_CTRL, 8'h09, "protected period");
        pw(8'h00);
        rd(A_CTRL, 8'h08, "wde ignored");
        wait_for(1'b1, 10000);
        check("cause two", {31'h0, cause}, 32'h1);
        close_out();
    end
endmodule
